/* logic/fws_map.svh */
// Constants for the flash write status reporting block: bit positions, times, counts
`ifndef FWS_MAP_SVH
`define FWS_MAP_SVH

// ****************************************
// Clock
// ****************************************
`define FWS_CLK_PERIOD_NS 5

// ****************************************
// Status bit positions in the data word
// ****************************************
`define FWS_POS_POLL     7
`define FWS_POS_TOG1     6
`define FWS_POS_TIMEOUT  5
`define FWS_POS_WIN      3
`define FWS_POS_TOG2     2

// ****************************************
// Times in their own units
// ****************************************
`define FWS_T_PROT_POLL_NS   1000
`define FWS_T_PROT_TOG_NS    1000000
`define FWS_T_PROT_ERASE_NS  100000
`define FWS_T_ERASE_WIN_NS   50000

// ****************************************
// Cycle counts derived from the times
// ****************************************
`define FWS_CYC_PROT_POLL  ((`FWS_T_PROT_POLL_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_CYC_PROT_TOG   ((`FWS_T_PROT_TOG_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_CYC_PROT_ERASE ((`FWS_T_PROT_ERASE_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_CYC_ERASE_WIN  ((`FWS_T_ERASE_WIN_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)

// ****************************************
// Burst ready handling
// ****************************************
`define FWS_BURST_BOUNDARY 6'h3F
`define FWS_WAIT_ONE       2'h1
`define FWS_WAIT_TWO       2'h2

// ****************************************
// Reset values
// ****************************************
`define FWS_RST_WORD   16'h0000
`define FWS_RST_TIMER  20'h00000

`endif

/* logic/fws_pkg.sv */
// Types shared by the flash write status reporting block
package fws_pkg;

  // ****************************************
  // Bank state
  // ****************************************
  typedef enum logic [2:0] {
    FWS_IDLE,
    FWS_PROG,
    FWS_PROT_PROG,
    FWS_ERASE_WIN,
    FWS_ERASE,
    FWS_PROT_ERASE,
    FWS_SUSP,
    FWS_SUSP_PROG
  } fws_state_t;

  // ****************************************
  // Whole state of the status block
  // ****************************************
  typedef struct packed {
    fws_state_t    st;           // Routine state of the busy bank
    logic [1:0]    bank;         // Bank running the routine
    logic [7:0]    prog_sector;  // Sector being programmed
    logic          prog_bit7;    // Target datum bit seven
    logic [255:0]  sel;          // Sectors chosen for erase
    logic [255:0]  prot;         // Protection of chosen sectors
    logic [19:0]   timer;        // Down counter for timed phases
    logic          tog1;         // Toggle bit one
    logic          tog2;         // Toggle bit two
    logic          timeout;      // Timeout flag
    logic          strobe_q;     // Previous filtered read strobe
    logic [15:0]   dq;           // Data word driven on reads
    logic          dq_drive;     // Data bus driven
    logic [1:0]    wait_cnt;     // Burst wait clocks left
    logic          erase_begin;  // Erase start pulse
  } fws_state_s_t;

endpackage : fws_pkg

/* logic/fws_status.sv */
// Write operation status reporting for one flash device with banked routines
`timescale 1ns/1ps
`include "fws_map.svh"

// Summary of operation
// (R1) Program reads give inverted target bit
// (R2) Erase polls zero; done or suspend polls one
// (R3) Protected program: polling active about one microsecond
// (R4) All-protected erase: status for 100 microseconds
// (R5) Partly protected erase skips protected sectors
// (R6) Polling valid from final write strobe
// (R7) Polling bit may settle before others
// (R8) Host polls at program or erase address
// (R9) Synchronous ready low means one/two waits
// (R10) Burst ready low initially, each 64 words
// (R11) Asynchronous ready open drain, low while busy
// (R12) Toggle bit one flips per busy read
// (R13) Toggle one valid through erase window
// (R14) Toggle one halts in suspend, resumes programming
// (R15) Protected program toggles one millisecond
// (R16) Toggle advances only on strobe re-assertion
// (R17) Toggle two flips in chosen erase sectors
// (R18) Suspended reads elsewhere return array data
// (R19) Host reads twice and compares toggle
// (R20) Host checks timeout flag, then resets
// (R21) Host rechecks polling after timeout flag
// (R22) Host restarts polling after leaving loop
// (R23) Timeout flag set on pulse limit
// (R24) Erase window flag zero then one
// (R25) Status only from the busy bank
module fws_status #(
  parameter int PROT_TOG_CYC   = `FWS_CYC_PROT_TOG,
  parameter int PROT_ERASE_CYC = `FWS_CYC_PROT_ERASE,
  parameter int ERASE_WIN_CYC  = `FWS_CYC_ERASE_WIN
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Host read strobes and address, array data
  input  wire logic         ce_n,
  input  wire logic         oe_n,
  input  wire logic [1:0]   rd_bank,
  input  wire logic [7:0]   rd_sector,
  input  wire logic [15:0]  array_data,
  // Data bus drive
  output logic      [15:0]  dq_out,
  output logic              dq_oe_n,
  // Ready pin
  output logic              rdy_out,
  output logic              rdy_oe_n,
  // Mode configuration
  input  wire logic         sync_mode,
  input  wire logic         rdy_wait_two,
  // Burst progress
  input  wire logic         burst_start,
  input  wire logic         burst_next,
  input  wire logic [5:0]   burst_word_addr,
  // Commands from the decoder, one cycle each
  input  wire logic         prog_start,
  input  wire logic         erase_cmd,
  input  wire logic [1:0]   cmd_bank,
  input  wire logic [7:0]   cmd_sector,
  input  wire logic         cmd_protected,
  input  wire logic         cmd_bit7,
  input  wire logic         erase_suspend,
  input  wire logic         erase_resume,
  input  wire logic         reset_cmd,
  // Routine engine
  input  wire logic         engine_done,
  input  wire logic         engine_limit,
  input  wire logic [7:0]   erase_query,
  output logic              erase_query_go,
  output logic              erase_begin,
  output logic              bank_busy,
  output logic              timeout_flag,
  output logic              erase_window_flag
);

  // ****************************************
  // Derived counts and constants
  // ****************************************
  localparam logic [19:0] TOG_CYC  = 20'(PROT_TOG_CYC);
  localparam logic [19:0] ERA_CYC  = 20'(PROT_ERASE_CYC);
  localparam logic [19:0] WIN_CYC  = 20'(ERASE_WIN_CYC);
  localparam logic [19:0] POLL_END = 20'(PROT_TOG_CYC - `FWS_CYC_PROT_POLL);

  // ****************************************
  // Signals
  // ****************************************
  fws_pkg::fws_state_s_t  r;           // Registered state
  fws_pkg::fws_state_s_t  next_r;      // Next state
  logic [1:0]             strobes;     // Filtered ce_n, oe_n
  logic                   rd_strobe_n; // Read strobe, low while reading
  logic                   read_start;  // One read begins
  logic                   is_busy;     // Routine in progress

  // ****************************************
  // Pin synchronisers
  // ****************************************
  fws_sync3 #(
    .WIDTH   (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    ({ce_n, oe_n}),
    .level_out (strobes)
  );

  // Read cycle is both strobes low; new read on re-assertion
  assign rd_strobe_n = strobes[1] | strobes[0];
  assign read_start  = r.strobe_q & ~rd_strobe_n; // R16

  // ****************************************
  // Decode helpers
  // ****************************************
  // States in which the routine keeps the bank busy
  function automatic logic fws_busy(input fws_pkg::fws_state_t s);
    case (s)
      fws_pkg::FWS_IDLE: fws_busy = 1'b0;
      fws_pkg::FWS_SUSP: fws_busy = 1'b0;
      default:           fws_busy = 1'b1;
    endcase
  endfunction : fws_busy

  // States in which erase sectors are chosen
  function automatic logic fws_erase_st(input fws_pkg::fws_state_t s);
    case (s)
      fws_pkg::FWS_ERASE_WIN:  fws_erase_st = 1'b1;
      fws_pkg::FWS_ERASE:      fws_erase_st = 1'b1;
      fws_pkg::FWS_PROT_ERASE: fws_erase_st = 1'b1;
      fws_pkg::FWS_SUSP:       fws_erase_st = 1'b1;
      default:                 fws_erase_st = 1'b0;
    endcase
  endfunction : fws_erase_st

  assign is_busy = fws_busy(r.st);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic        hit;     // Read aimed at the busy bank
    logic        in_sel;  // Read inside a chosen erase sector
    logic        show;    // Read returns status
    logic        poll;    // Polling bit value
    logic [15:0] word;    // Status word
    hit    = 1'b0;
    in_sel = 1'b0;
    show   = 1'b0;
    poll   = 1'b0;
    word   = `FWS_RST_WORD;
    next_r = r;
    next_r.erase_begin = 1'b0;
    next_r.strobe_q    = rd_strobe_n;
    next_r.dq_drive    = ~rd_strobe_n;
    // Timed phases count down
    if (r.timer != `FWS_RST_TIMER) begin
      next_r.timer = r.timer - 20'h00001;
    end

    // Routine sequencing
    case (r.st)
      // Reading array; take a new routine
      fws_pkg::FWS_IDLE: begin
        if (prog_start) begin
          next_r.bank        = cmd_bank;
          next_r.prog_sector = cmd_sector;
          next_r.prog_bit7   = cmd_bit7;
          next_r.timeout     = 1'b0;
          if (cmd_protected) begin
            next_r.st    = fws_pkg::FWS_PROT_PROG; // R15
            next_r.timer = TOG_CYC;
          end else begin
            next_r.st = fws_pkg::FWS_PROG; // R6
          end
        end else if (erase_cmd) begin
          next_r.bank              = cmd_bank;
          next_r.sel               = '0;
          next_r.prot              = '0;
          next_r.sel[cmd_sector]   = 1'b1;
          next_r.prot[cmd_sector]  = cmd_protected;
          next_r.timeout           = 1'b0;
          next_r.st                = fws_pkg::FWS_ERASE_WIN; // R13
          next_r.timer             = WIN_CYC;
        end
      end
      // Program runs until the engine finishes
      fws_pkg::FWS_PROG: begin
        if (engine_done) begin
          next_r.st = fws_pkg::FWS_IDLE;
        end
      end
      // Protected program: status then array read
      fws_pkg::FWS_PROT_PROG: begin
        if (r.timer == `FWS_RST_TIMER) begin
          next_r.st = fws_pkg::FWS_IDLE; // R3
        end
      end
      // Erase window takes more sectors
      fws_pkg::FWS_ERASE_WIN: begin
        if (erase_cmd && (cmd_bank == r.bank)) begin
          next_r.sel[cmd_sector]  = 1'b1;
          next_r.prot[cmd_sector] = cmd_protected;
          next_r.timer            = WIN_CYC;
        end else if (r.timer == `FWS_RST_TIMER) begin
          if ((r.sel & ~r.prot) == '0) begin
            next_r.st    = fws_pkg::FWS_PROT_ERASE; // R4
            next_r.timer = ERA_CYC;
          end else begin
            next_r.st          = fws_pkg::FWS_ERASE; // R24
            next_r.erase_begin = 1'b1;
          end
        end
      end
      // Erase runs; only suspend accepted
      fws_pkg::FWS_ERASE: begin
        if (engine_done) begin
          next_r.st = fws_pkg::FWS_IDLE;
        end else if (erase_suspend) begin
          next_r.st = fws_pkg::FWS_SUSP; // R14
        end
      end
      // All chosen sectors protected
      fws_pkg::FWS_PROT_ERASE: begin
        if (r.timer == `FWS_RST_TIMER) begin
          next_r.st = fws_pkg::FWS_IDLE; // R4
        end
      end
      // Erase suspended; resume or program elsewhere
      fws_pkg::FWS_SUSP: begin
        if (erase_resume) begin
          next_r.st = fws_pkg::FWS_ERASE;
        end else if (prog_start && (cmd_bank == r.bank)) begin
          next_r.prog_sector = cmd_sector;
          next_r.prog_bit7   = cmd_bit7;
          next_r.st          = fws_pkg::FWS_SUSP_PROG; // R14
        end
      end
      // Program during suspend
      fws_pkg::FWS_SUSP_PROG: begin
        if (engine_done) begin
          next_r.st = fws_pkg::FWS_SUSP;
        end
      end
      default: begin
        next_r.st = fws_pkg::FWS_IDLE;
      end
    endcase

    // Reset command leaves a failed routine
    if (reset_cmd && r.timeout) begin
      next_r.timeout = 1'b0;
      if (r.st == fws_pkg::FWS_SUSP_PROG) begin
        next_r.st = fws_pkg::FWS_SUSP;
      end else begin
        next_r.st = fws_pkg::FWS_IDLE;
      end
    end
    // Pulse limit sets the flag; set wins over clear
    if (engine_limit && is_busy) begin
      next_r.timeout = 1'b1; // R23
    end

    // Read response
    hit    = (rd_bank == r.bank);
    in_sel = r.sel[rd_sector];
    show   = hit && (r.st != fws_pkg::FWS_IDLE); // R25
    if (r.st == fws_pkg::FWS_SUSP && !in_sel) begin
      show = 1'b0; // R18
    end
    // Polling bit per state
    case (r.st)
      fws_pkg::FWS_PROG:      poll = ~r.prog_bit7; // R1
      fws_pkg::FWS_SUSP_PROG: poll = ~r.prog_bit7; // R1
      fws_pkg::FWS_PROT_PROG: poll = (r.timer > POLL_END) ? ~r.prog_bit7 : array_data[7]; // R3
      fws_pkg::FWS_SUSP:      poll = 1'b1; // R2
      default:                poll = 1'b0; // R2
    endcase
    if (read_start) begin
      if (show) begin
        // Toggle bit one flips while a routine is active
        if (is_busy) begin
          next_r.tog1 = ~r.tog1; // R12
        end
        // Toggle bit two flips in chosen sectors only
        if (fws_erase_st(r.st) && in_sel) begin
          next_r.tog2 = ~r.tog2; // R17
        end
        word[`FWS_POS_POLL]    = poll; // R6
        word[`FWS_POS_TOG1]    = next_r.tog1; // R13
        word[`FWS_POS_TIMEOUT] = r.timeout; // R23
        word[`FWS_POS_WIN]     = fws_erase_st(r.st) && (r.st != fws_pkg::FWS_ERASE_WIN); // R24
        word[`FWS_POS_TOG2]    = next_r.tog2; // R17
        next_r.dq = word; // R7
      end else begin
        next_r.dq = array_data; // R25
      end
    end

    // Burst wait clocks for the ready pin
    if (burst_start) begin
      next_r.wait_cnt = rdy_wait_two ? `FWS_WAIT_TWO : `FWS_WAIT_ONE; // R9
    end else if (burst_next && (burst_word_addr == `FWS_BURST_BOUNDARY)) begin
      next_r.wait_cnt = rdy_wait_two ? `FWS_WAIT_TWO : `FWS_WAIT_ONE; // R10
    end else if (r.wait_cnt != 2'h0) begin
      next_r.wait_cnt = r.wait_cnt - 2'h1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{st: fws_pkg::FWS_IDLE, strobe_q: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Data bus from flip-flops
  assign dq_out  = r.dq;
  assign dq_oe_n = ~r.dq_drive;

  // Ready pin: synchronous drives under chip select, else open drain
  always_comb begin
    if (sync_mode) begin
      rdy_out  = (r.wait_cnt == 2'h0); // R9
      rdy_oe_n = strobes[1]; // R10
    end else begin
      rdy_out  = 1'b0; // R11
      rdy_oe_n = ~is_busy; // R11
    end
  end

  // Engine side
  assign erase_query_go    = r.sel[erase_query] & ~r.prot[erase_query]; // R5
  assign erase_begin       = r.erase_begin;
  assign bank_busy         = is_busy;
  assign timeout_flag      = r.timeout;
  assign erase_window_flag = fws_erase_st(r.st) && (r.st != fws_pkg::FWS_ERASE_WIN);

endmodule : fws_status

/* logic/fws_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fws_sync3 #(
  parameter int          WIDTH   = 2,
  parameter logic [1:0]  RST_VAL = 2'h3
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Pins in, filtered levels out
  input  wire logic [WIDTH-1:0]  pin_in,
  output logic      [WIDTH-1:0]  level_out
);

  // ****************************************
  // One chain per bit
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic s1;   // First stage, read only by s2
      logic s2;   // Second stage
      logic s3;   // Third stage
      logic lvl;  // Accepted level

      // Shift chain; level moves when stages two and three agree
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1  <= RST_VAL[g];
          s2  <= RST_VAL[g];
          s3  <= RST_VAL[g];
          lvl <= RST_VAL[g];
        end else begin
          s1 <= pin_in[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end

      assign level_out[g] = lvl;
    end
  endgenerate

endmodule : fws_sync3

/* tb/flash_write_status_reporting_test.sv */
// Self-checking bench for the flash write status block
`timescale 1ns/1ps
`include "fws_map.svh"
module flash_write_status_reporting_test;
  // ****************
  // Shortened counts and signals
  // ****************
  localparam int WIN = 100;
  localparam int PE  = 200;
  localparam int PT  = 400;
  logic        core_clk = 1'b0, rst_n = 1'b0, sync_mode = 1'b0, rdy_wait_two = 1'b0;
  logic        ce_n, oe_n, dq_oe_n, rdy_out, rdy_oe_n, cmd_protected = 1'b0, cmd_bit7 = 1'b0;
  logic [1:0]  rd_bank, cmd_bank = 2'h0, b;
  logic [7:0]  rd_sector, cmd_sector = 8'h00, erase_query = 8'h00, s;
  logic [15:0] dq_out, array_data = 16'h0000, w0, w1;
  logic [5:0]  burst_word_addr = 6'h00;
  logic [8:0]  pv = 9'h000;
  logic        prog_start, erase_cmd, erase_suspend, erase_resume, reset_cmd, t;
  logic        engine_done, engine_limit, burst_start, burst_next;
  logic        erase_query_go, erase_begin, bank_busy, timeout_flag, erase_window_flag;
  logic [31:0] seed = 32'h0000D372;
  int          failures = 0, n_compared = 0, cyc, lows = 0, l0, nb;
  time         tm;
  assign {burst_next, burst_start, engine_limit, engine_done, reset_cmd, erase_resume,
          erase_suspend, erase_cmd, prog_start} = pv;
  always #2.5 core_clk = ~core_clk;
  // Wait clocks seen in sync mode
  always @(posedge core_clk) if (sync_mode && rdy_out === 1'b0) lows <= lows + 1;
  fws_status #(.PROT_TOG_CYC(PT), .PROT_ERASE_CYC(PE), .ERASE_WIN_CYC(WIN)) DUT (.core_clk,
    .rst_n, .ce_n, .oe_n, .rd_bank, .rd_sector, .array_data, .dq_out, .dq_oe_n, .rdy_out,
    .rdy_oe_n, .sync_mode, .rdy_wait_two, .burst_start, .burst_next, .burst_word_addr,
    .prog_start, .erase_cmd, .cmd_bank, .cmd_sector, .cmd_protected, .cmd_bit7,
    .erase_suspend, .erase_resume, .reset_cmd, .engine_done, .engine_limit, .erase_query,
    .erase_query_go, .erase_begin, .bank_busy, .timeout_flag, .erase_window_flag);
  fws_host HOST (.core_clk, .ce_n, .oe_n, .rd_bank, .rd_sector, .dq_out, .dq_oe_n);
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // Expected status word
  function automatic logic [15:0] stat(input logic p, t1, t2, to, wf);
    stat = 16'h0000;
    stat[`FWS_POS_POLL] = p;
    stat[`FWS_POS_TOG1] = t1;
    stat[`FWS_POS_TOG2] = t2;
    stat[`FWS_POS_TIMEOUT] = to;
    stat[`FWS_POS_WIN] = wf;
  endfunction : stat
  task automatic chk(input logic [15:0] got, exp, input logic [15:0] m = 16'hFFFF);
    n_compared++;
    if ($isunknown(got & m) || (got & m) !== (exp & m)) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One command pulse with its qualifiers
  task automatic go(input int k, input logic p = 1'b0, input logic bt = 1'b0);
    @(posedge core_clk);
    cmd_bank <= b;
    cmd_sector <= s;
    cmd_protected <= p;
    cmd_bit7 <= bt;
    pv <= 9'h001 << k;
    @(posedge core_clk);
    pv <= 9'h000;
    tm = $time;
  endtask : go
  task automatic rd2(input logic [7:0] sec);
    HOST.read(b, sec, w0);
    HOST.read(b, sec, w1);
  endtask : rd2
  // Wait for erase start (1) or idle bank (0)
  task automatic wt(input logic which, input int lim);
    cyc = 0;
    while ((which ? erase_begin : bank_busy) !== which && cyc < lim) begin
      @(posedge core_clk);
      cyc++;
    end
    chk(16'(cyc < lim), 16'h0001);
  endtask : wt
  function automatic logic [15:0] spent(input int lo, hi);
    return 16'(($time - tm) / 5 inside {[lo:hi]});
  endfunction : spent
  task automatic results;
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    #100000;
    failures++;
    results();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    seed = xs(seed);
    {t, s, b} = seed[10:0];
    go(0, 1'b0, t);
    rd2(s);
    chk(w1, stat(~t, ~w0[6], w0[2], 1'b0, 1'b0), 16'hFFF7);
    chk(16'(rdy_oe_n), 16'h0000);
    array_data <= seed[31:16];
    HOST.read(b + 2'h1, s, w0);
    chk(w0, array_data);
    array_data <= {seed[31:24], t, seed[22:16]};
    go(5);
    rd2(s);
    chk(w1, array_data);
    chk(16'(rdy_oe_n), 16'h0001);
    seed = xs(seed);
    {s, b} = seed[9:0];
    go(1);
    rd2(s);
    chk(w1, stat(1'b0, ~w0[6], ~w0[2], 1'b0, 1'b0), 16'hFF7F);
    s = s + 8'h01;
    go(1, 1'b1);
    for (int i = -1; i < 2; i++) begin
      erase_query <= s + 8'(i);
      repeat (2) @(posedge core_clk);
      chk(16'(erase_query_go), 16'(i == -1));
    end
    s = s - 8'h01;
    wt(1'b1, 3 * WIN);
    chk(16'(erase_window_flag), 16'h0001);
    rd2(s);
    chk(w1, stat(1'b0, ~w0[6], ~w0[2], 1'b0, 1'b1));
    rd2(s + 8'h02);
    chk(w1, stat(1'b0, ~w0[6], w0[2], 1'b0, 1'b1), 16'hFF7F);
    go(2);
    rd2(s);
    chk(w1, stat(1'b1, w0[6], ~w0[2], 1'b0, 1'b1));
    array_data <= seed[15:0];
    HOST.read(b, s + 8'h02, w0);
    chk(w0, array_data);
    go(3);
    go(5);
    wt(1'b0, 10);
    rd2(s);
    chk(w1, array_data);
    go(1, 1'b1);
    rd2(s);
    chk(w1, stat(1'b0, ~w0[6], 1'b0, 1'b0, 1'b0), 16'h00C0);
    wt(1'b0, WIN + PE + 20);
    chk(spent(WIN + PE - 4, WIN + PE + 8), 16'h0001);
    go(0, 1'b1, t);
    rd2(s);
    chk(w1, stat(~t, ~w0[6], 1'b0, 1'b0, 1'b0), 16'h00C0);
    // Past the polling window the top bit follows the array
    array_data <= {seed[15:8], t, seed[6:0]};
    repeat (200) @(posedge core_clk);
    HOST.read(b, s, w0);
    chk(w0, array_data, 16'h0080);
    wt(1'b0, PT + 20);
    chk(spent(PT - 4, PT + 8), 16'h0001);
    go(0);
    go(6);
    rd2(s);
    chk(w1, stat(1'b0, ~w0[6], 1'b0, 1'b1, 1'b0), 16'h0060);
    chk(16'(timeout_flag), 16'h0001);
    go(4);
    wt(1'b0, 4);
    sync_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      rdy_wait_two <= k[0];
      nb = 1;
      go(7);
      l0 = lows;
      for (int i = 0; i < 70; i++) begin
        burst_word_addr <= seed[5:0] + 6'(i);
        nb += int'(seed[5:0] + 6'(i) == 6'h3F);
        go(8);
      end
      repeat (4) @(posedge core_clk);
      chk(16'(lows - l0), 16'(nb * (k + 1)));
    end
    chk(16'(rdy_oe_n), 16'h0001);
    results();
  end
endmodule : flash_write_status_reporting_test

/* tb/fws_host.sv */
// Host controller model reading status words
`timescale 1ns/1ps
module fws_host (
  // Clock
  input wire logic        core_clk,
  // Strobes and address
  output logic            ce_n,
  output logic            oe_n,
  output logic [1:0]      rd_bank,
  output logic [7:0]      rd_sector,
  // Data bus
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe_n
);
  // Deselected at start
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    rd_bank = 2'h0;
    rd_sector = 8'h00;
  end
  // One read, strobes released after each word
  task automatic read(input logic [1:0] b, input logic [7:0] s, output logic [15:0] w);
    int n;
    @(posedge core_clk);
    rd_bank <= b;
    rd_sector <= s;
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (dq_oe_n !== 1'b0 && n < 20);
    w = dq_out;
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    rd_bank <= ~b;
    rd_sector <= ~s;
    repeat (6) @(posedge core_clk);
  endtask : read
endmodule : fws_host

/* tb/fws_status_chk.sv */
// Checker for the status block ports
`timescale 1ns/1ps
module fws_status_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Watched inputs
  input wire logic       ce_n,
  input wire logic       sync_mode,
  input wire logic       rdy_wait_two,
  input wire logic       burst_next,
  input wire logic [5:0] burst_word_addr,
  input wire logic       prog_start,
  input wire logic       erase_cmd,
  input wire logic       engine_limit,
  // Watched outputs
  input wire logic       dq_oe_n,
  input wire logic       rdy_out,
  input wire logic       rdy_oe_n,
  input wire logic       erase_begin,
  input wire logic       bank_busy,
  input wire logic       timeout_flag,
  input wire logic       erase_window_flag
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Two cycles of slack for registered pins
  sequence s_busy; (!sync_mode && bank_busy) [*2]; endsequence
  sequence s_free; (!sync_mode && !bank_busy) [*2]; endsequence
  sequence s_begin; erase_window_flag && bank_busy ##1 !erase_begin; endsequence
  property p_prog_busy; prog_start && !bank_busy |=> bank_busy; endproperty
  property p_erase_win;
    erase_cmd && !bank_busy && !erase_window_flag |=> bank_busy && !erase_window_flag;
  endproperty
  property p_begin; erase_begin |-> s_begin; endproperty
  property p_limit; engine_limit && bank_busy |=> timeout_flag; endproperty
  property p_async_busy; s_busy |-> !rdy_oe_n && !rdy_out; endproperty
  property p_async_free; s_free |-> rdy_oe_n; endproperty
  property p_ce_idle; ce_n [*8] |-> dq_oe_n; endproperty
  property p_wait_one; $fell(rdy_out) && sync_mode && !rdy_wait_two |=> rdy_out; endproperty
  // Rise after a two-clock wait needs two low samples
  property p_wait_two;
    $rose(rdy_out) && sync_mode && $past(sync_mode) && $past(rdy_wait_two) && $past(rst_n, 3)
      |-> !$past(rdy_out, 2);
  endproperty
  property p_boundary;
    burst_next && burst_word_addr == 6'h3F && sync_mode |-> ##[1:2] !rdy_out;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("program left bank idle");
  a_erase_win: assert property (p_erase_win) else $error("erase window flag wrong");
  a_begin: assert property (p_begin) else $error("erase start pulse wrong");
  a_limit: assert property (p_limit) else $error("timeout flag not set");
  a_async_busy: assert property (p_async_busy) else $error("ready not low");
  a_async_free: assert property (p_async_free) else $error("ready not floating");
  a_ce_idle: assert property (p_ce_idle) else $error("data driven unselected");
  a_wait_one: assert property (p_wait_one) else $error("one clock wait wrong");
  a_wait_two: assert property (p_wait_two) else $error("two clock wait wrong");
  a_boundary: assert property (p_boundary) else $error("no wait at boundary");
endmodule : fws_status_chk
bind fws_status fws_status_chk CHK (.core_clk, .rst_n, .ce_n, .sync_mode, .rdy_wait_two,
  .burst_next, .burst_word_addr, .prog_start, .erase_cmd, .engine_limit, .dq_oe_n, .rdy_out,
  .rdy_oe_n, .erase_begin, .bank_busy, .timeout_flag, .erase_window_flag);
